// file: hw/dmc_channel_control.v
// Multi-channel DMA control: APB register file, channel sequencing, chaining and arbitration.
//
// Our own choice: register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "dmc_regs.vh"

module dmc_channel_control #(
  parameter NCH = 4
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [15:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  input wire [NCH-1:0] ch_start_evt,
  input wire [NCH-1:0] ch_abort_evt,
  output wire xfer_req,
  output wire [2:0] xfer_ch,
  input wire xfer_ack,
  input wire [7:0] xfer_rdata,
  input wire xfer_last,
  input wire xfer_err,
  input wire xfer_err_write,
  input wire [31:0] xfer_err_addr,
  output wire global_transfer_active,
  output wire irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers.

  function [31:0] alias_apply;
    input [31:0] old;
    input [31:0] wd;
    input [1:0] kind;
    begin
      case (kind)
        `DMC_ALIAS_CLR: alias_apply = old & ~wd;
        `DMC_ALIAS_SET: alias_apply = old | wd;
        `DMC_ALIAS_INV: alias_apply = old ^ wd;
        default: alias_apply = wd;
      endcase
    end
  endfunction

  function hit;
    input [15:0] addr;
    input [15:0] base;
    begin
      hit = (addr[15:4] == base[15:4]);
    end
  endfunction

  // Highest priority code wins; on a tie the lowest channel number wins.
  function [3:0] arbitrate;
    input [NCH-1:0] elig;
    input [2*NCH-1:0] pri;
    integer k;
    reg [1:0] best;
    reg found;
    reg [2:0] idx;
    begin
      best = 2'h0;
      found = 1'b0;
      idx = 3'h0;
      for (k = 0; k < NCH; k = k + 1) begin
        if (elig[k] && (!found || pri[2*k +: 2] > best)) begin
          found = 1'b1;
          best = pri[2*k +: 2];
          idx = k[2:0];
        end
      end
      arbitrate = {found, idx};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State.

  reg [31:0] gctl_ff;
  reg [3:0] gstat_ff;
  reg [31:0] faddr_ff;
  reg [31:0] ckctl_ff;
  reg [31:0] ckval_ff;
  reg [31:0] ckpoly_ff;
  reg [31:0] ist_ff;
  reg [31:0] imsk_ff;
  reg [NCH-1:0] pmode_ff;
  reg [`DMC_CTL_W*NCH-1:0] ctl_ff;
  reg [8*NCH-1:0] pat_ff;
  reg [NCH-1:0] edet_ff;
  reg cur_valid_ff;
  reg [2:0] cur_ch_ff;

  reg [31:0] nxt_gctl;
  reg [3:0] nxt_gstat;
  reg [31:0] nxt_faddr;
  reg [31:0] nxt_ckctl;
  reg [31:0] nxt_ckval;
  reg [31:0] nxt_ckpoly;
  reg [31:0] nxt_ist;
  reg [31:0] nxt_imsk;
  reg [NCH-1:0] nxt_pmode;
  reg [`DMC_CTL_W*NCH-1:0] nxt_ctl;
  reg [8*NCH-1:0] nxt_pat;
  reg [NCH-1:0] nxt_edet;
  reg nxt_cur_valid;
  reg [2:0] nxt_cur_ch;
  reg [31:0] nxt_prdata;
  reg nxt_pslverr;

  wire wr_en = psel & penable & pwrite;
  wire setup = psel & ~penable;
  wire [1:0] kind = paddr[3:2];
  wire ch_page = (paddr[15:8] == `DMC_CH_PAGE) && ({1'b0, paddr[7:5]} < NCH);
  wire [2:0] ch_idx = paddr[7:5];
  wire ch_pat_sel = paddr[4];

  wire g_on = gctl_ff[`DMC_GCTL_ON];
  wire g_susp = gctl_ff[`DMC_GCTL_SUSP];
  wire beat_done = cur_valid_ff & xfer_ack;

  ////////////////////////////////////////////////////////////////////////////////
  // Per-channel status terms.

  wire [NCH-1:0] ch_en;
  wire [NCH-1:0] ch_take_evt;
  wire [NCH-1:0] ch_busy;
  wire [NCH-1:0] blk_done;
  wire [NCH-1:0] ch_abort;
  wire [NCH-1:0] ch_elig;
  wire [2*NCH-1:0] ch_pri;

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      wire [`DMC_CTL_W-1:0] c = ctl_ff[`DMC_CTL_W*g +: `DMC_CTL_W];
      wire mine = cur_valid_ff && (cur_ch_ff == g);
      assign ch_en[g] = c[`DMC_CTL_EN];
      assign ch_pri[2*g +: 2] = c[1:0];
      // Events count only when enabled, or when allowed while off.
      assign ch_take_evt[g] = c[`DMC_CTL_EN] | c[`DMC_CTL_AED];
      // A disabled channel stays busy until its outstanding beat is acknowledged.
      assign ch_busy[g] = c[`DMC_CTL_EN] | mine;
      assign blk_done[g] = mine & xfer_ack & ~xfer_err &
        (xfer_last | (pmode_ff[g] & (xfer_rdata == pat_ff[8*g +: 8])));
      assign ch_abort[g] = (ch_abort_evt[g] & ch_take_evt[g]) |
        (mine & xfer_ack & xfer_err);
      assign ch_elig[g] = c[`DMC_CTL_EN] & edet_ff[g] & g_on & ~g_susp;
    end
  endgenerate

  // Neighbour completions seen from each channel: the higher-numbered
  // neighbour has lower natural priority.
  wire [NCH:0] blk_pad_hi = {1'b0, blk_done};
  wire [NCH:0] blk_pad_lo = {blk_done, 1'b0};
  wire [NCH-1:0] blk_from_lower = blk_pad_hi[NCH:1];
  wire [NCH-1:0] blk_from_higher = blk_pad_lo[NCH-1:0];

  wire [3:0] arb = arbitrate(ch_elig, ch_pri);

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  integer i;
  // The read path has its own loop index so that no variable has two driving processes.
  integer j;
  reg [`DMC_CTL_W-1:0] c_new;
  reg [31:0] tmp;
  reg chain_set;

  always @* begin
    c_new = `DMC_RST_CTL;
    tmp = `DMC_RST_WORD;
    chain_set = 1'b0;
    nxt_gctl = gctl_ff;
    nxt_gstat = gstat_ff;
    nxt_faddr = faddr_ff;
    nxt_ckctl = ckctl_ff;
    nxt_ckval = ckval_ff;
    nxt_ckpoly = ckpoly_ff;
    nxt_ist = ist_ff;
    nxt_imsk = imsk_ff;
    nxt_pmode = pmode_ff;
    nxt_ctl = ctl_ff;
    nxt_pat = pat_ff;
    nxt_edet = edet_ff;
    nxt_cur_valid = cur_valid_ff;
    nxt_cur_ch = cur_ch_ff;

    // Software writes; read-only registers ignore writes through all aliases.
    if (wr_en) begin
      if (hit(paddr, `DMC_OFS_GCTL)) begin
        nxt_gctl = alias_apply(gctl_ff, pwdata, kind) & `DMC_GCTL_WMASK;
      end
      if (hit(paddr, `DMC_OFS_CKCTL)) begin
        nxt_ckctl = alias_apply(ckctl_ff, pwdata, kind) & `DMC_CKCTL_WMASK;
      end
      if (hit(paddr, `DMC_OFS_CKVAL)) begin
        nxt_ckval = alias_apply(ckval_ff, pwdata, kind);
      end
      if (hit(paddr, `DMC_OFS_CKPOLY)) begin
        nxt_ckpoly = alias_apply(ckpoly_ff, pwdata, kind);
      end
      if (hit(paddr, `DMC_OFS_IMSK)) begin
        nxt_imsk = alias_apply(imsk_ff, pwdata, kind);
      end
      if (hit(paddr, `DMC_OFS_PMODE)) begin
        tmp = alias_apply({{(32-NCH){1'b0}}, pmode_ff}, pwdata, kind);
        nxt_pmode = tmp[NCH-1:0];
      end
      if (hit(paddr, `DMC_OFS_IST) && kind == `DMC_ALIAS_PLAIN) begin
        nxt_ist = ist_ff & ~pwdata;
      end
      for (i = 0; i < NCH; i = i + 1) begin
        if (ch_page && ch_idx == i && !ch_pat_sel) begin
          tmp = alias_apply({23'h0, ctl_ff[`DMC_CTL_W*i +: `DMC_CTL_W]}, pwdata, kind);
          nxt_ctl[`DMC_CTL_W*i +: `DMC_CTL_W] = tmp[8:0] & `DMC_CTL_WMASK;
        end
        if (ch_page && ch_idx == i && ch_pat_sel) begin
          tmp = alias_apply({24'h0, pat_ff[8*i +: 8]}, pwdata, kind);
          nxt_pat[8*i +: 8] = tmp[7:0];
        end
      end
    end

    // Hardware updates take precedence over a same-cycle software write.
    for (i = 0; i < NCH; i = i + 1) begin
      c_new = nxt_ctl[`DMC_CTL_W*i +: `DMC_CTL_W];
      chain_set = c_new[`DMC_CTL_CHN] &
        (c_new[`DMC_CTL_CHNS] ? blk_from_lower[i] : blk_from_higher[i]);
      if (blk_done[i] && !c_new[`DMC_CTL_AEN]) begin
        c_new[`DMC_CTL_EN] = 1'b0;
      end
      if (ch_abort[i]) begin
        c_new[`DMC_CTL_EN] = 1'b0;
      end
      if (chain_set) begin
        c_new[`DMC_CTL_EN] = 1'b1;
      end
      nxt_ctl[`DMC_CTL_W*i +: `DMC_CTL_W] = c_new;
      if (blk_done[i] || ch_abort[i]) begin
        nxt_edet[i] = 1'b0;
      end
      if (ch_start_evt[i] && ch_take_evt[i]) begin
        nxt_edet[i] = 1'b1;
      end
      if (blk_done[i]) begin
        nxt_ist[i] = 1'b1;
      end
      if (ch_abort[i]) begin
        nxt_ist[`DMC_IST_ABT_LSB + i] = 1'b1;
      end
    end

    if (beat_done && xfer_err) begin
      nxt_faddr = xfer_err_addr;
      nxt_gstat = {xfer_err_write, cur_ch_ff};
      nxt_ist[`DMC_IST_ERR_BIT] = 1'b1;
    end

    // One beat outstanding at a time; arbitration reruns after every beat.
    if (beat_done) begin
      nxt_cur_valid = 1'b0;
    end else if (!cur_valid_ff && arb[3]) begin
      nxt_cur_valid = 1'b1;
      nxt_cur_ch = arb[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB read path: data is captured in the setup phase so prdata comes from a
  // flip-flop and the access phase needs no wait state.

  always @* begin
    nxt_prdata = `DMC_RST_WORD;
    nxt_pslverr = 1'b0;
    if (hit(paddr, `DMC_OFS_GCTL)) begin
      nxt_prdata = gctl_ff;
      nxt_prdata[`DMC_GCTL_BUSY] = cur_valid_ff;
    end else if (hit(paddr, `DMC_OFS_GSTAT)) begin
      nxt_prdata = {28'h0, gstat_ff};
    end else if (hit(paddr, `DMC_OFS_FADDR)) begin
      nxt_prdata = faddr_ff;
    end else if (hit(paddr, `DMC_OFS_CKCTL)) begin
      nxt_prdata = ckctl_ff;
    end else if (hit(paddr, `DMC_OFS_CKVAL)) begin
      nxt_prdata = ckval_ff;
    end else if (hit(paddr, `DMC_OFS_CKPOLY)) begin
      nxt_prdata = ckpoly_ff;
    end else if (hit(paddr, `DMC_OFS_IST)) begin
      nxt_prdata = ist_ff;
    end else if (hit(paddr, `DMC_OFS_IMSK)) begin
      nxt_prdata = imsk_ff;
    end else if (hit(paddr, `DMC_OFS_PMODE)) begin
      nxt_prdata = {{(32-NCH){1'b0}}, pmode_ff};
    end else if (ch_page) begin
      for (j = 0; j < NCH; j = j + 1) begin
        if (ch_idx == j) begin
          if (ch_pat_sel) begin
            nxt_prdata = {24'h0, pat_ff[8*j +: 8]};
          end else begin
            nxt_prdata = {23'h0, ctl_ff[`DMC_CTL_W*j +: `DMC_CTL_W]};
            nxt_prdata[`DMC_CTL_BUSY_BIT] = ch_busy[j];
            nxt_prdata[`DMC_CTL_EDET_BIT] = edet_ff[j];
          end
        end
      end
    end else begin
      nxt_pslverr = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers.

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gctl_ff <= `DMC_RST_WORD;
      gstat_ff <= 4'h0;
      faddr_ff <= `DMC_RST_WORD;
      ckctl_ff <= `DMC_RST_WORD;
      ckval_ff <= `DMC_RST_WORD;
      ckpoly_ff <= `DMC_RST_WORD;
      ist_ff <= `DMC_RST_WORD;
      imsk_ff <= `DMC_RST_WORD;
      pmode_ff <= {NCH{1'b0}};
      ctl_ff <= {NCH{`DMC_RST_CTL}};
      pat_ff <= {(8*NCH){1'b0}};
      edet_ff <= {NCH{1'b0}};
      cur_valid_ff <= 1'b0;
      cur_ch_ff <= 3'h0;
      prdata <= `DMC_RST_WORD;
      pslverr <= 1'b0;
    end else begin
      gctl_ff <= nxt_gctl;
      gstat_ff <= nxt_gstat;
      faddr_ff <= nxt_faddr;
      ckctl_ff <= nxt_ckctl;
      ckval_ff <= nxt_ckval;
      ckpoly_ff <= nxt_ckpoly;
      ist_ff <= nxt_ist;
      imsk_ff <= nxt_imsk;
      pmode_ff <= nxt_pmode;
      ctl_ff <= nxt_ctl;
      pat_ff <= nxt_pat;
      edet_ff <= nxt_edet;
      cur_valid_ff <= nxt_cur_valid;
      cur_ch_ff <= nxt_cur_ch;
      if (setup) begin
        prdata <= nxt_prdata;
        pslverr <= nxt_pslverr;
      end
    end
  end

  assign pready = 1'b1;
  // A beat request is never withdrawn before its acknowledge, even when the
  // channel is disabled meanwhile, so the far side sees a clean handshake.
  assign xfer_req = cur_valid_ff;
  assign xfer_ch = cur_ch_ff;
  assign global_transfer_active = cur_valid_ff;
  assign irq = |(ist_ff & imsk_ff);

endmodule // dmc_channel_control

`default_nettype wire

// file: hw/dmc_regs.vh
// Register map, field positions and reset values of the DMA channel control block.
`ifndef DMC_REGS_VH
`define DMC_REGS_VH

`define DMC_OFS_GCTL 16'h3000
`define DMC_OFS_GSTAT 16'h3010
`define DMC_OFS_FADDR 16'h3020
`define DMC_OFS_CKCTL 16'h3030
`define DMC_OFS_CKVAL 16'h3040
`define DMC_OFS_CKPOLY 16'h3050
`define DMC_OFS_IST 16'h3100
`define DMC_OFS_IMSK 16'h3110
`define DMC_OFS_PMODE 16'h3120
`define DMC_CH_PAGE 8'h32

`define DMC_ALIAS_PLAIN 2'h0
`define DMC_ALIAS_CLR 2'h1
`define DMC_ALIAS_SET 2'h2
`define DMC_ALIAS_INV 2'h3

`define DMC_GCTL_ON 15
`define DMC_GCTL_SUSP 12
`define DMC_GCTL_BUSY 11
`define DMC_GCTL_WMASK 32'h0000_9000
`define DMC_CKCTL_WMASK 32'h3900_1FE7

`define DMC_CTL_WMASK 9'h1F3
`define DMC_CTL_CHNS 8
`define DMC_CTL_EN 7
`define DMC_CTL_AED 6
`define DMC_CTL_CHN 5
`define DMC_CTL_AEN 4
`define DMC_CTL_BUSY_BIT 15
`define DMC_CTL_EDET_BIT 2
`define DMC_CTL_W 9

`define DMC_IST_ABT_LSB 8
`define DMC_IST_ERR_BIT 16

`define DMC_RST_WORD 32'h0000_0000
`define DMC_RST_CTL 9'h000

`endif

// file: tb/dmc_channel_control_checker.sv
// Port-level assertions for the DMA channel control block.
`timescale 1ns/10ps
`default_nettype none
module dmc_checker #(
  parameter NCH = 4
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [15:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [NCH-1:0] ch_start_evt,
  input wire [NCH-1:0] ch_abort_evt,
  input wire xfer_req,
  input wire [2:0] xfer_ch,
  input wire xfer_ack,
  input wire [7:0] xfer_rdata,
  input wire xfer_last,
  input wire xfer_err,
  input wire xfer_err_write,
  input wire [31:0] xfer_err_addr,
  input wire global_transfer_active,
  input wire irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wait; xfer_req && !xfer_ack; endsequence
  sequence s_done; xfer_req && xfer_ack; endsequence
  wire rd_acc = psel && penable && !pwrite;
  chk_req_holds: assert property (s_wait |=> xfer_req && $stable(xfer_ch))
    else $error("beat request dropped before acknowledge");
  chk_req_release: assert property (s_done |=> !xfer_req)
    else $error("beat request kept after acknowledge");
  chk_busy_match: assert property (xfer_req |-> global_transfer_active)
    else $error("busy low while a beat is outstanding");
  chk_ch_range: assert property (xfer_req |-> xfer_ch < NCH)
    else $error("beat for a channel that does not exist");
  chk_ctl_pad: assert property (rd_acc && paddr[15:8] == 8'h32 && !paddr[4] |->
    prdata[31:16] == 16'h0 && prdata[14:9] == 6'h0 && !prdata[3])
    else $error("control register pad bits not zero");
  chk_pat_pad: assert property (rd_acc && paddr[15:8] == 8'h32 && paddr[4] |->
    prdata[31:8] == 24'h0) else $error("pattern register upper bits not zero");
  chk_gctl_pad: assert property (rd_acc && paddr == 16'h3000 |->
    prdata[31:16] == 16'h0 && prdata[14:13] == 2'h0 && prdata[10:0] == 11'h0)
    else $error("global control pad bits not zero");
  chk_err_zero: assert property (rd_acc && pslverr |-> prdata == 32'h0)
    else $error("refused read returned data");
  chk_reset_idle: assert property ($rose(presetn) |-> !xfer_req && !irq)
    else $error("outputs active straight after reset");
endmodule // dmc_checker
bind dmc_channel_control dmc_checker #(.NCH(NCH)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .ch_start_evt(ch_start_evt),
  .ch_abort_evt(ch_abort_evt), .xfer_req(xfer_req), .xfer_ch(xfer_ch), .xfer_ack(xfer_ack),
  .xfer_rdata(xfer_rdata), .xfer_last(xfer_last), .xfer_err(xfer_err),
  .xfer_err_write(xfer_err_write), .xfer_err_addr(xfer_err_addr),
  .global_transfer_active(global_transfer_active), .irq(irq));
`default_nettype wire

// file: tb/dmc_xfer_model.sv
// Far-side memory model that completes one beat after a set wait.
`timescale 1ns/10ps
`default_nettype none
module dmc_xfer_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic xfer_req,
  input wire logic [2:0] wait_cycles,
  input wire logic last_beat,
  input wire logic [7:0] beat_data,
  output logic xfer_ack,
  output logic [7:0] xfer_rdata,
  output logic xfer_last
);
  logic [2:0] cnt_ff;
  // Outside an acknowledge the data byte toggles, so nothing can lean on a stale value.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 3'h0;
      xfer_ack <= 1'h0;
      xfer_rdata <= 8'h00;
      xfer_last <= 1'h0;
    end else if (xfer_req && !xfer_ack && cnt_ff == wait_cycles) begin
      cnt_ff <= 3'h0;
      xfer_ack <= 1'h1;
      xfer_rdata <= beat_data;
      xfer_last <= last_beat;
    end else begin
      cnt_ff <= (xfer_req && !xfer_ack) ? cnt_ff + 3'h1 : 3'h0;
      xfer_ack <= 1'h0;
      xfer_rdata <= ~xfer_rdata;
      xfer_last <= 1'h0;
    end
  end
endmodule // dmc_xfer_model
`default_nettype wire

// file: tb/dmc_channel_control_tb.sv
// Self-checking testbench for the DMA channel control block.
`timescale 1ns/10ps
`default_nettype none
module dmc_channel_control_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, xfer_req, xfer_ack, xfer_last;
  logic global_transfer_active, irq, last_beat;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] ch_start_evt, ch_abort_evt;
  logic [2:0] xfer_ch;
  logic [7:0] xfer_rdata, beat_data;
  int mismatches, n_compared;
  dmc_channel_control #(.NCH(4)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ch_start_evt(ch_start_evt),
    .ch_abort_evt(ch_abort_evt), .xfer_req(xfer_req), .xfer_ch(xfer_ch), .xfer_ack(xfer_ack),
    .xfer_rdata(xfer_rdata), .xfer_last(xfer_last), .xfer_err(1'h0), .xfer_err_write(1'h0),
    .xfer_err_addr(32'h0), .global_transfer_active(global_transfer_active), .irq(irq));
  dmc_xfer_model u_far (.pclk(pclk), .presetn(presetn), .xfer_req(xfer_req),
    .wait_cycles(3'h2), .last_beat(last_beat), .beat_data(beat_data), .xfer_ack(xfer_ack),
    .xfer_rdata(xfer_rdata), .xfer_last(xfer_last));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    q = prdata;
    psel <= 1'h0; penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'h1, a, d, q);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(1'h0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic evt(input logic [3:0] s, input logic [3:0] b);
    ch_start_evt <= s; ch_abort_evt <= b;
    @(posedge pclk);
    ch_start_evt <= 4'h0; ch_abort_evt <= 4'h0;
    @(posedge pclk);
  endtask
  task automatic beat(input logic [2:0] ch);
    int n;
    n = 0;
    while (xfer_req !== 1'h1 && n < 20) begin @(posedge pclk); n++; end
    chk({29'h0, xfer_ch}, {29'h0, ch});
    chk({31'h0, global_transfer_active}, 32'h1);
    while (xfer_req === 1'h1) @(posedge pclk);
    repeat (2) @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_alias;
    logic [31:0] q;
    for (int i = 0; i < 6; i++) rd(16'h3000 + 16'(i * 16), 32'h0);
    rd(16'h3200, 32'h0);
    apb(1'h0, 16'h3F00, 32'h0, q);
    chk({31'h0, pslverr}, 32'h1);
    wr(16'h3050, 32'hFFFF0000); wr(16'h3058, 32'h000000FF);
    wr(16'h3054, 32'hF0000000); wr(16'h305C, 32'h0000000F);
    rd(16'h3050, 32'h0FFF00F0);
    wr(16'h3030, 32'hFFFFFFFF); rd(16'h3030, 32'h39001FE7);
    wr(16'h3000, 32'hFFFFFFFF); rd(16'h3000, 32'h00009000);
    wr(16'h3004, 32'h00001000); rd(16'h3000, 32'h00008000);
  endtask
  task automatic t_fields;
    wr(16'h3210, 32'hFFFFFFFF); rd(16'h3210, 32'h000000FF);
    wr(16'h3200, 32'hFFFFFFFF); rd(16'h3200, 32'h000081F3);
    wr(16'h3200, 32'h0); rd(16'h3200, 32'h0);
    evt(4'h4, 4'h0); rd(16'h3240, 32'h0);
    wr(16'h3240, 32'h40); evt(4'h4, 4'h0); rd(16'h3240, 32'h44);
    evt(4'h0, 4'h4); rd(16'h3240, 32'h40);
  endtask
  task automatic t_chain;
    wr(16'h3240, 32'h80); wr(16'h3260, 32'h20); wr(16'h3220, 32'h100);
    evt(4'h4, 4'h0); beat(3'h2);
    rd(16'h3260, 32'h80A0);
    rd(16'h3220, 32'h100);
    rd(16'h3240, 32'h0);
    wr(16'h3260, 32'h0); wr(16'h3220, 32'h0);
  endtask
  task automatic t_block_irq;
    wr(16'h3220, 32'h83); evt(4'h2, 4'h0); beat(3'h1);
    rd(16'h3220, 32'h03);
    chk({31'h0, irq}, 32'h0);
    wr(16'h3110, 32'h2); chk({31'h0, irq}, 32'h1);
    rd(16'h3100, 32'h406);
    wr(16'h3100, 32'h2); chk({31'h0, irq}, 32'h0);
    wr(16'h3200, 32'h90); wr(16'h3220, 32'h83); evt(4'h3, 4'h0);
    beat(3'h1); beat(3'h0);
    rd(16'h3200, 32'h8090);
    wr(16'h3200, 32'h0); wr(16'h3220, 32'h0);
  endtask
  task automatic t_global_off;
    wr(16'h3004, 32'h00008000);
    wr(16'h3200, 32'h80); evt(4'h1, 4'h0);
    repeat (8) @(posedge pclk);
    chk({31'h0, xfer_req}, 32'h0);
    wr(16'h3008, 32'h00008000); beat(3'h0);
    wr(16'h3200, 32'h0);
  endtask
  task automatic t_pattern;
    logic [31:0] q;
    int n;
    wr(16'h3120, 32'h1); wr(16'h3210, 32'h5A);
    last_beat <= 1'h0; beat_data <= 8'h5A;
    wr(16'h3200, 32'h80); evt(4'h1, 4'h0); beat(3'h0);
    rd(16'h3200, 32'h0);
    wr(16'h3120, 32'h0); wr(16'h3200, 32'h80); evt(4'h1, 4'h0); beat(3'h0);
    rd(16'h3200, 32'h8084);
    wr(16'h3200, 32'h0);
    n = 0;
    do begin apb(1'h0, 16'h3200, 32'h0, q); n++; end while (q[15] !== 1'h0 && n < 10);
    chk({31'h0, q[15]}, 32'h0);
  endtask
  task automatic tally_and_finish;
    if (mismatches == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'h0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    #100us;
    mismatches++;
    tally_and_finish;
  end
  initial begin
    presetn = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = 16'h0;
    pwdata = 32'h0; ch_start_evt = 4'h0; ch_abort_evt = 4'h0;
    last_beat = 1'h1; beat_data = 8'h00; mismatches = 0; n_compared = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_reset_alias;
    t_fields;
    t_chain;
    t_block_irq;
    t_global_off;
    t_pattern;
    tally_and_finish;
  end
endmodule // dmc_channel_control_tb
`default_nettype wire
